// [rtl/timer_overflow_clock_control.sv]
// Global control of a two-channel timer: APB control register, clock source select,
// crystal clock synchronizer, prescaler, 16-bit counter with wrap flag, interrupts and
// pin ownership. Assumes channel logic supplies modulo value and per-pin needs.
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"

// Notes on behaviour
// - A timer-owned input pin may have its passive pull-up enabled.
// - After reset the timer is off, pins follow port controls, pull-ups off.
// - Timer-owned pins ignore port data and direction; otherwise port controls rule.
// - Up-counting: wrap flag sets when counter rolls from modulo to zero.
// - Center mode: wrap flag sets when counter steps down from modulo.
// - Wrap flag clears by reading control while set, then writing zero.
// - A wrap between that read and write restarts the clear sequence.
// - Writing one to the wrap flag does nothing; reset clears it.
// - Overflow interrupt requested while enable and wrap flag are both one.
// - Center select one: all channels center PWM; zero: per-channel modes.
// - Reset clears center select, giving plain up-counting.
// - Two-bit clock source field in bits 4..3 disables or selects source.
// - Crystal-derived clock is synchronized to the bus clock before use.
// - Three-bit prescale field in bits 2..0 divides by two to the code.
// - Prescaler follows source selection and synchronization.
// - Source codes: 00 off, 01 bus clock, 10 unused, 11 crystal-derived.
// - Crystal-derived source is a 500 kHz clock from the radio crystal.
module timer_overflow_clock_control
    import timer_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int NUM_CH = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Crystal-derived 500 kHz clock, asynchronous to clk_sys
    input wire logic crystal_derived_clock,
    // Channel side
    input wire logic [CNT_W-1:0] modulo_value,
    input wire logic [NUM_CH-1:0] chan_pin_needed,
    input wire logic [NUM_CH-1:0] chan_pin_is_input,
    input wire logic [NUM_CH-1:0] chan_pin_out,
    output logic [CNT_W-1:0] count_value,
    output logic count_tick,
    output logic center_aligned_pwm,
    // Port controls and pins
    input wire logic [NUM_CH-1:0] gpio_data,
    input wire logic [NUM_CH-1:0] gpio_dir,
    output logic [NUM_CH-1:0] pin_o,
    output logic [NUM_CH-1:0] pin_oe,
    output logic [NUM_CH-1:0] pin_pullup,
    // Interrupts
    output logic wrap_irq,
    output logic irq
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, `TMR_OFF_CTRL) | hit(a, `TMR_OFF_STAT) | hit(a, `TMR_OFF_MASK)
                 | hit(a, `TMR_OFF_PIN) | hit(a, `TMR_OFF_COUNT);
    endfunction

    // ****************************************************************
    // APB handshake: one wait state, answer on the second access cycle
    // ****************************************************************
    logic pready_r;
    logic acc;
    logic wr_acc;
    logic rd_acc;

    assign acc = psel & penable & pready_r;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= psel & penable & ~pready_r;
        end
    end

    // ****************************************************************
    // Control, mask and pull-up enable registers
    // ****************************************************************
    logic irq_en_r;
    logic center_r;
    clk_src_t src_r;
    logic [2:0] ps_r;
    logic wrap_flag_r;
    logic [`TMR_EV_W-1:0] stat_r;
    logic [`TMR_EV_W-1:0] mask_r;
    logic [NUM_CH-1:0] pullup_en_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_en_r <= 1'b0;
            center_r <= 1'b0;
            src_r <= SRC_OFF;
            ps_r <= 3'h0;
        end else if (wr_acc && hit(paddr, `TMR_OFF_CTRL)) begin
            irq_en_r <= pwdata[`TMR_IRQEN_BIT];
            center_r <= pwdata[`TMR_CENTER_BIT];
            src_r <= clk_src_t'(pwdata[`TMR_CLKS_HI:`TMR_CLKS_LO]);
            ps_r <= pwdata[`TMR_PS_HI:`TMR_PS_LO];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_r <= '0;
            pullup_en_r <= `TMR_PIN_RST;
        end else if (wr_acc) begin
            if (hit(paddr, `TMR_OFF_MASK)) begin
                mask_r <= pwdata[`TMR_EV_W-1:0];
            end
            if (hit(paddr, `TMR_OFF_PIN)) begin
                pullup_en_r <= pwdata[NUM_CH-1:0];
            end
        end
    end

    // ****************************************************************
    // Crystal clock synchronizer and edge detect
    // ****************************************************************
    logic xtal_s1_r;
    logic xtal_s2_r;
    logic xtal_s3_r;
    logic xtal_rise;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_s3_r <= 1'b0;
        end else begin
            xtal_s1_r <= crystal_derived_clock;
            xtal_s2_r <= xtal_s1_r;
            xtal_s3_r <= xtal_s2_r;
        end
    end

    assign xtal_rise = xtal_s2_r & ~xtal_s3_r;

    // ****************************************************************
    // Source select and prescaler
    // ****************************************************************
    logic src_tick;
    logic [6:0] pre_r;
    logic [6:0] pre_mask;
    logic pre_tick;

    always_comb begin
        case (src_r)
            SRC_BUS: src_tick = 1'b1;
            SRC_XTAL: src_tick = xtal_rise;
            SRC_OFF: src_tick = 1'b0;
            SRC_UNUSED: src_tick = 1'b0;
            default: src_tick = 1'b0;
        endcase
    end

    // The divider counts source ticks, so the divisor applies after selection.
    assign pre_mask = 7'((8'h01 << ps_r) - 8'h01);
    assign pre_tick = src_tick & ((pre_r & pre_mask) == pre_mask);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pre_r <= 7'h00;
        end else if (src_tick) begin
            pre_r <= 7'(pre_r + 7'h01);
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic [CNT_W-1:0] cnt_r;
    count_dir_t dir_r;
    logic [CNT_W-1:0] top;
    logic wrap_ev;

    // A modulo of zero leaves the counter free-running over the full range.
    assign top = (modulo_value == CNT_W'(`TMR_CNT_ZERO)) ? CNT_W'(`TMR_CNT_FREE) : modulo_value;
    assign wrap_ev = pre_tick & (cnt_r == top) & ((~center_r) | (dir_r == DIR_UP));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= '0;
            dir_r <= DIR_UP;
        end else if (pre_tick) begin
            if (!center_r) begin
                dir_r <= DIR_UP;
                cnt_r <= (cnt_r == top) ? '0 : CNT_W'(cnt_r + 1'b1);
            end else if (dir_r == DIR_UP) begin
                if (cnt_r == top) begin
                    dir_r <= DIR_DOWN;
                    cnt_r <= CNT_W'(cnt_r - 1'b1);
                end else begin
                    cnt_r <= CNT_W'(cnt_r + 1'b1);
                end
            end else begin
                if (cnt_r == '0) begin
                    dir_r <= DIR_UP;
                    cnt_r <= CNT_W'(cnt_r + 1'b1);
                end else begin
                    cnt_r <= CNT_W'(cnt_r - 1'b1);
                end
            end
        end
    end

    // ****************************************************************
    // Wrap flag and its two-step clear
    // ****************************************************************
    clr_state_t clr_r;
    logic ctrl_rd;
    logic ctrl_wr;

    assign ctrl_rd = rd_acc & hit(paddr, `TMR_OFF_CTRL);
    assign ctrl_wr = wr_acc & hit(paddr, `TMR_OFF_CTRL);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrap_flag_r <= 1'b0;
            clr_r <= CLR_IDLE;
        end else begin
            case (clr_r)
                CLR_IDLE: begin
                    if (ctrl_rd && wrap_flag_r && !wrap_ev) begin
                        clr_r <= CLR_ARMED;
                    end
                end
                CLR_ARMED: begin
                    // Any new wrap disarms, so the pending write cannot drop it.
                    if (wrap_ev || ctrl_wr) begin
                        clr_r <= CLR_IDLE;
                    end
                end
                default: clr_r <= CLR_IDLE;
            endcase
            if (wrap_ev) begin
                wrap_flag_r <= 1'b1;
            end else if (clr_r == CLR_ARMED && ctrl_wr && !pwdata[`TMR_WRAP_BIT]) begin
                wrap_flag_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Sticky status, write one to clear; set wins over clear
    // ****************************************************************
    logic [`TMR_EV_W-1:0] ev;
    logic [`TMR_EV_W-1:0] stat_clr;

    assign ev[`TMR_EV_WRAP] = wrap_ev;
    assign ev[`TMR_EV_BADSRC] = ctrl_wr && (pwdata[`TMR_CLKS_HI:`TMR_CLKS_LO] == 2'(SRC_UNUSED));
    assign stat_clr = (wr_acc && hit(paddr, `TMR_OFF_STAT)) ? pwdata[`TMR_EV_W-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | ev;
        end
    end

    // ****************************************************************
    // Read data and error answer
    // ****************************************************************
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit(paddr, `TMR_OFF_CTRL)) begin
            rd_nxt[`TMR_WRAP_BIT] = wrap_flag_r;
            rd_nxt[`TMR_IRQEN_BIT] = irq_en_r;
            rd_nxt[`TMR_CENTER_BIT] = center_r;
            rd_nxt[`TMR_CLKS_HI:`TMR_CLKS_LO] = src_r;
            rd_nxt[`TMR_PS_HI:`TMR_PS_LO] = ps_r;
        end else if (hit(paddr, `TMR_OFF_STAT)) begin
            rd_nxt[`TMR_EV_W-1:0] = stat_r;
        end else if (hit(paddr, `TMR_OFF_MASK)) begin
            rd_nxt[`TMR_EV_W-1:0] = mask_r;
        end else if (hit(paddr, `TMR_OFF_PIN)) begin
            rd_nxt[NUM_CH-1:0] = pullup_en_r;
        end else if (hit(paddr, `TMR_OFF_COUNT)) begin
            rd_nxt[CNT_W-1:0] = cnt_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && penable && !pready_r && !pwrite) ? rd_nxt : 32'h0000_0000;
            pslverr <= psel && penable && !pready_r && !mapped(paddr);
        end
    end

    assign pready = pready_r;

    // ****************************************************************
    // Pin ownership
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_pin
            logic owns;
            assign owns = chan_pin_needed[g] && (src_r != SRC_OFF);
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    pin_o[g] <= 1'b0;
                    pin_oe[g] <= 1'b0;
                    pin_pullup[g] <= 1'b0;
                end else begin
                    pin_o[g] <= owns ? chan_pin_out[g] : gpio_data[g];
                    pin_oe[g] <= owns ? !chan_pin_is_input[g] : gpio_dir[g];
                    pin_pullup[g] <= owns && chan_pin_is_input[g] && pullup_en_r[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Outputs to channels and interrupts
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_value <= '0;
            count_tick <= 1'b0;
            center_aligned_pwm <= 1'b0;
            wrap_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            count_value <= cnt_r;
            count_tick <= pre_tick;
            center_aligned_pwm <= center_r;
            wrap_irq <= irq_en_r & wrap_flag_r;
            irq <= |(stat_r & mask_r);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_wrap_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
        wrap_ev |=> wrap_flag_r) else $error("wrap event did not set flag");
    a_up_roll_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (wrap_ev && !center_r) |=> cnt_r == '0) else $error("counter did not roll to zero");
    a_center_down: assert property (@(posedge clk_sys) disable iff (rst)
        (wrap_ev && center_r && top != '0) |=> dir_r == DIR_DOWN && cnt_r == $past(top) - 1'b1)
        else $error("center wrap did not step down");
    a_clear_needs_read: assert property (@(posedge clk_sys) disable iff (rst)
        ($fell(wrap_flag_r)) |-> $past(clr_r) == CLR_ARMED) else $error("flag cleared without read");
    a_rewrap_restarts: assert property (@(posedge clk_sys) disable iff (rst)
        (clr_r == CLR_ARMED && wrap_ev) |=> clr_r == CLR_IDLE && wrap_flag_r)
        else $error("new wrap did not restart clear");
    a_one_write_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        (wrap_flag_r && ctrl_wr && pwdata[`TMR_WRAP_BIT]) |=> wrap_flag_r) else $error("write one cleared flag");
    a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
        wrap_irq == $past(irq_en_r & wrap_flag_r)) else $error("wrap interrupt mismatch");
    a_hold_no_source: assert property (@(posedge clk_sys) disable iff (rst)
        (src_r == SRC_OFF) |=> $stable(cnt_r) && !count_tick) else $error("counter moved with no source");
    a_div_spacing: assert property (@(posedge clk_sys) disable iff (rst)
        (src_r == SRC_BUS && ps_r == 3'h1 && $stable(ps_r) && $stable(src_r) && pre_tick) |=> !pre_tick)
        else $error("divide by two ticked twice");
    a_owned_pin: assert property (@(posedge clk_sys) disable iff (rst)
        (chan_pin_needed[0] && src_r != SRC_OFF) |=> pin_o[0] == $past(chan_pin_out[0]))
        else $error("owned pin followed port data");

    c_up_wrap: cover property (@(posedge clk_sys) disable iff (rst) wrap_ev && !center_r);
    c_center_wrap: cover property (@(posedge clk_sys) disable iff (rst) wrap_ev && center_r);
    c_clear_done: cover property (@(posedge clk_sys) disable iff (rst) $fell(wrap_flag_r));
    c_xtal_tick: cover property (@(posedge clk_sys) disable iff (rst) src_r == SRC_XTAL && pre_tick);

endmodule
`default_nettype wire

// [rtl/timer_params.svh]
// Constants for the timer global control and clock block: offsets, field positions,
// reset values and derived counts. Assumes 32-bit APB data with one register per word.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TMR_OFF_CTRL 8'h10
`define TMR_OFF_STAT 8'h20
`define TMR_OFF_MASK 8'h24
`define TMR_OFF_PIN 8'h28
`define TMR_OFF_COUNT 8'h2c

// ****************************************************************
// Control register fields
// ****************************************************************
`define TMR_WRAP_BIT 7
`define TMR_IRQEN_BIT 6
`define TMR_CENTER_BIT 5
`define TMR_CLKS_HI 4
`define TMR_CLKS_LO 3
`define TMR_PS_HI 2
`define TMR_PS_LO 0

// ****************************************************************
// Status and mask bits
// ****************************************************************
`define TMR_EV_WRAP 0
`define TMR_EV_BADSRC 1
`define TMR_EV_W 2

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define TMR_CTRL_RST 8'h00
`define TMR_PIN_RST 2'h0
`define TMR_CNT_ZERO 16'h0000
`define TMR_CNT_FREE 16'hffff
`define TMR_PS_MAX_CODE 3'h7

`endif

// [rtl/timer_pkg.sv]
// Types shared by the timer global control and clock block.
// Assumes timer_params.svh holds the numeric constants.
package timer_pkg;

    // ****************************************************************
    // Clock source codes in field order
    // ****************************************************************
    typedef enum logic [1:0] {SRC_OFF, SRC_BUS, SRC_UNUSED, SRC_XTAL} clk_src_t;

    // ****************************************************************
    // Wrap-flag clear sequence and count direction
    // ****************************************************************
    typedef enum logic {CLR_IDLE, CLR_ARMED} clr_state_t;
    typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage

// [verification/pin_side_model.sv]
// Far-side model: the radio crystal clock and the two pads shared with the port.
// Assumes the timer drives pin_o and pin_oe and offers a pull-up per pad.
`timescale 1ns/10ps
`default_nettype none
module pin_side_model (
    // Crystal clock control
    input wire logic xtal_run,
    output logic xtal_clk,
    // Pads
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] pin_pullup,
    output logic [1:0] pad
);
    // ****************************************************************
    // Clock and pad levels
    // ****************************************************************
    logic [1:0] last_r = 2'h0;

    // The clock stands low while stopped; the odd start offset keeps it unrelated to clk_sys.
    initial begin
        xtal_clk = 1'b0;
        #333;
        forever begin
            #1000;
            xtal_clk = xtal_run ? ~xtal_clk : 1'b0;
        end
    end

    always @(pin_o or pin_oe) begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe[i]) begin
                last_r[i] = pin_o[i];
            end
        end
    end

    // An undriven pad without pull-up shows the inverse of its last level, never a stale copy.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pad[i] = pin_oe[i] ? pin_o[i] : (pin_pullup[i] ? 1'b1 : ~last_r[i]);
        end
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the timer global control block, driven over APB.
// Assumes pin_side_model.sv and the design files under rtl/.
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d, e;
    logic xtal_run, xtal_clk, count_tick, center_aligned_pwm, wrap_irq, irq;
    logic [15:0] modulo_value, count_value;
    logic [1:0] chan_pin_needed, chan_pin_is_input, chan_pin_out, gpio_data, gpio_dir, pin_o, pin_oe, pin_pullup, pad;
    int fail_count, checks, g;

    timer_overflow_clock_control uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_derived_clock(xtal_clk), .modulo_value(modulo_value), .chan_pin_needed(chan_pin_needed),
        .chan_pin_is_input(chan_pin_is_input), .chan_pin_out(chan_pin_out), .count_value(count_value),
        .count_tick(count_tick), .center_aligned_pwm(center_aligned_pwm), .gpio_data(gpio_data),
        .gpio_dir(gpio_dir), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .wrap_irq(wrap_irq),
        .irq(irq));
    pin_side_model partner (.xtal_run(xtal_run), .xtal_clk(xtal_clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pad(pad));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Bus and timing tasks
    // ****************************************************************
    task automatic results;
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Entered just after a rising edge; ends one idle edge later so no strobe is driven twice at once.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            results();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        apb(1'b1, a, wd, x);
    endtask

    task automatic gap(output int n);
        int w;
        w = 0;
        while (count_tick !== 1'b1 && w < 4000) begin
            @(posedge clk_sys);
            w++;
        end
        @(posedge clk_sys);
        n = 1;
        while (count_tick !== 1'b1 && n < 4000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 4000 || w >= 4000) begin
            fail_count++;
            results();
        end
    endtask

    // Counts how often the sample after top is the expected next value; any other successor is a miss.
    task automatic watch(input logic [15:0] top, input logic [15:0] nxt, output int hits);
        logic [15:0] prev;
        hits = 0;
        prev = count_value;
        repeat (60) begin
            @(posedge clk_sys);
            if (prev === top) begin
                hits = (count_value === nxt && hits >= 0) ? hits + 1 : -100;
            end
            prev = count_value;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, xtal_run} = {1'b1, 44'h0};
        // A short modulo makes sure a wrap lands between the read and the write of the race test.
        {modulo_value, chan_pin_is_input, chan_pin_out} = {16'h0002, 2'h1, 2'h2};
        {chan_pin_needed, gpio_data, gpio_dir} = {2'h3, 2'h1, 2'h2};
        fail_count = 0;
        checks = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        `CHK("ctrl reset", 32'h0, d)
        `CHK("pin_oe reset", gpio_dir, pin_oe)
        `CHK("pullup reset", 2'h0, pin_pullup)
        `CHK("center reset", 1'b0, center_aligned_pwm)
        apb(1'b0, 8'h30, 32'h0, d);
        `CHK("unmapped err", 1'b1, last_err)
        `CHK("unmapped data", 32'h0, d)
        wr(`TMR_OFF_CTRL, 32'h08);
        watch(16'h0002, 16'h0000, g);
        `CHK("up rollover", 1'b1, g > 0)
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        wr(`TMR_OFF_CTRL, 32'h08);
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        `CHK("wrap in race", 1'b1, d[7])
        wr(`TMR_OFF_CTRL, 32'h80);
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        `CHK("write one keeps", 1'b1, d[7])
        wr(`TMR_OFF_CTRL, 32'hc0);
        repeat (2) @(posedge clk_sys);
        `CHK("irq with flag", 1'b1, wrap_irq)
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        wr(`TMR_OFF_CTRL, 32'h40);
        repeat (2) @(posedge clk_sys);
        `CHK("irq cleared", 1'b0, wrap_irq)
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        `CHK("flag cleared", 32'h40, d)
        wr(`TMR_OFF_MASK, 32'h1);
        repeat (2) @(posedge clk_sys);
        `CHK("status irq", 1'b1, irq)
        wr(`TMR_OFF_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        `CHK("status w1c", 1'b0, irq)
        wr(`TMR_OFF_CTRL, 32'h28);
        @(posedge clk_sys);
        `CHK("center out", 1'b1, center_aligned_pwm)
        watch(16'h0002, 16'h0001, g);
        `CHK("center turn", 1'b1, g > 0)
        apb(1'b0, `TMR_OFF_CTRL, 32'h0, d);
        `CHK("center wrap", 1'b1, d[7])
        modulo_value <= 16'h0000;
        for (int ps = 0; ps < 8; ps++) begin
            wr(`TMR_OFF_CTRL, 32'h08 | ps);
            gap(g);
            gap(g);
            `CHK("prescale gap", 1 << ps, g)
        end
        xtal_run <= 1'b1;
        wr(`TMR_OFF_CTRL, 32'h19);
        gap(g);
        gap(g);
        `CHK("xtal gap", 1'b1, g >= 158 && g <= 162)
        xtal_run <= 1'b0;
        wr(`TMR_OFF_CTRL, 32'h10);
        apb(1'b0, `TMR_OFF_STAT, 32'h0, d);
        `CHK("unused code", 1'b1, d[1])
        apb(1'b0, `TMR_OFF_COUNT, 32'h0, d);
        repeat (200) @(posedge clk_sys);
        apb(1'b0, `TMR_OFF_COUNT, 32'h0, e);
        `CHK("count held", d, e)
        wr(`TMR_OFF_PIN, 32'h3);
        wr(`TMR_OFF_CTRL, 32'h0f);
        gpio_dir <= 2'h3;
        repeat (2) @(posedge clk_sys);
        `CHK("owned oe", 2'h2, pin_oe)
        `CHK("owned pullup", 2'h1, pin_pullup)
        `CHK("pad level", 2'h3, pad)
        chan_pin_needed <= 2'h1;
        gpio_dir <= 2'h1;
        repeat (3) @(posedge clk_sys);
        `CHK("released pin", 2'h0, pin_o)
        `CHK("released oe", 2'h0, pin_oe)
        `CHK("released pullup", 2'h1, pin_pullup)
        results();
    end
endmodule
`default_nettype wire
